// ### rtl/spdp_driver.sv
// Function
// - level selects decode to 0/38/71/100 percent
// - direction high drives plus to minus
// - both selects low gives high impedance
// - standby low disables oscillator and drivers
// - thermal fault latches all bridge drives off (osc_en keeps running)
// - thermal latch clears on reboot or standby pulse
// - outputs except chop_level off until both supplies valid
// - per-channel overcurrent latches that channel off
// - overcurrent latch clears on reboot or standby low
// - controller keeps direction rate 1k-400k Hz (host clamps only the 400k Hz end; a larger HALF_CYC goes below 1k Hz)
// - controller keeps input edges fast
// - controller holds selects low at power-up
// - standby low clears only the overcurrent latches
`timescale 1ns/1ps
module spdp_driver (
    input wire logic clk,                              // 25 mhz clock
    input wire logic rst_n,                            // async reset, active low
    spdp_if.dev link,                                  // controller pins
    input wire logic motor_supply_ok,                  // motor supply monitor, pin
    input wire logic logic_supply_ok,                  // logic supply monitor, pin
    input wire logic thermal_shutdown,                 // thermal fault indication, pin
    input wire logic [spdp_pkg::SPDP_NUM_CHAN-1:0] overcurrent_shutdown, // per channel
    output logic [spdp_pkg::SPDP_NUM_CHAN-1:0] drive_pos, // high side of plus leg
    output logic [spdp_pkg::SPDP_NUM_CHAN-1:0] drive_neg, // high side of minus leg
    output logic [spdp_pkg::SPDP_NUM_CHAN-1:0] out_oe_n,  // low = bridge driven
    output logic [2*spdp_pkg::SPDP_NUM_CHAN*7-1:0] chop_level, // pct per channel
    output logic osc_en,                               // chopping oscillator enable
    output logic therm_latched,                        // latched thermal state
    output logic [spdp_pkg::SPDP_NUM_CHAN-1:0] ocp_latched // latched overcurrent
);
    import spdp_pkg::*;
    localparam int N = SPDP_NUM_CHAN;
    ////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for every pin input; first stage feeds only second
    localparam int SW = 4 * N + 4;
    logic [SW-1:0] meta_q, sync_q;
    logic [SW-1:0] pins;
    assign pins = {link.dir, link.sel_hi, link.sel_lo, overcurrent_shutdown,
                   link.standby_n, motor_supply_ok, logic_supply_ok, thermal_shutdown};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
        end
    end
    logic [N-1:0] s_dir, s_hi, s_lo, s_oc;
    logic s_sb, s_vm, s_vcc, s_tsd;
    assign {s_dir, s_hi, s_lo, s_oc, s_sb, s_vm, s_vcc, s_tsd} = sync_q;

    ////////////////////////////////////////////////////////////////////////
    // power-on hold-off and fault latches
    logic por_ok;
    logic therm_d, therm_q;
    logic [N-1:0] ocp_d, ocp_q;
    spdp_sb_t sb_d, sb_q;
    assign por_ok = s_vm & s_vcc;
    // standby edge tracker; a fresh high after a low releases the thermal latch
    always_comb begin
        sb_d = sb_q;
        therm_d = therm_q;
        ocp_d = ocp_q;
        unique case (sb_q)
            SPDP_SB_IDLE: begin
                if (s_sb) sb_d = SPDP_SB_SAW_HI;
            end
            SPDP_SB_SAW_HI: begin
                if (!s_sb) sb_d = SPDP_SB_SAW_LO;
            end
            SPDP_SB_SAW_LO: begin
                if (s_sb) sb_d = SPDP_SB_SAW_HI;
            end
            default: sb_d = SPDP_SB_IDLE;
        endcase
        // thermal clear sequence; a fault present wins over the clear
        if (sb_q == SPDP_SB_SAW_LO && s_sb) therm_d = 1'b0;
        if (s_tsd) therm_d = 1'b1;
        // standby low clears the overcurrent latches only
        if (!s_sb) ocp_d = '0;
        // per-channel overcurrent latch set, set beats the standby clear
        ocp_d = ocp_d | s_oc;
        // reboot through supply monitors clears latches
        if (!por_ok) begin
            therm_d = 1'b0;
            ocp_d = '0;
            sb_d = SPDP_SB_IDLE;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sb_q <= SPDP_SB_IDLE;
            therm_q <= 1'b0;
            ocp_q <= '0;
        end else begin
            sb_q <= sb_d;
            therm_q <= therm_d;
            ocp_q <= ocp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel decode; outputs all registered
    logic [N-1:0] pos_d, neg_d, oe_n_d;
    logic [2*N*7-1:0] lvl_d;
    logic osc_d;
    // oscillator runs only out of standby, supplies valid
    assign osc_d = s_sb & por_ok;
    genvar c;
    generate
        for (c = 0; c < N; c++) begin : g_chan
            spdp_mag_t mag;
            logic run;
            // magnitude decode; same for every channel
            assign mag = spdp_mag_t'({s_hi[c], s_lo[c]});
            assign run = osc_d & !therm_q & !ocp_q[c] & (mag != SPDP_MAG_0);
            // one continuous driver per lane slice, so no two processes share lvl_d
            assign lvl_d[c*7 +: 7] = (mag == SPDP_MAG_100) ? SPDP_PCT_100 :
                                     (mag == SPDP_MAG_71) ? SPDP_PCT_71 :
                                     (mag == SPDP_MAG_38) ? SPDP_PCT_38 : SPDP_PCT_0;
            assign lvl_d[(N+c)*7 +: 7] = 7'h00; // spare lanes read zero
            // high impedance when off; direction sets leg
            assign oe_n_d[c] = !run;
            assign pos_d[c] = run & s_dir[c];
            assign neg_d[c] = run & !s_dir[c];
        end
    endgenerate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_pos <= '0;
            drive_neg <= '0;
            out_oe_n <= '1;
            chop_level <= '0;
            osc_en <= 1'b0;
            therm_latched <= 1'b0;
            ocp_latched <= '0;
        end else begin
            drive_pos <= pos_d;
            drive_neg <= neg_d;
            out_oe_n <= oe_n_d;
            chop_level <= lvl_d;
            osc_en <= osc_d;
            therm_latched <= therm_q;
            ocp_latched <= ocp_q;
        end
    end
endmodule : spdp_driver

// ### rtl/spdp_pkg.sv
package spdp_pkg;
    // magnitude codes from the two level selects {hi, lo}
    typedef enum logic [1:0] {
        SPDP_MAG_0 = 2'h0,
        SPDP_MAG_38 = 2'h1,
        SPDP_MAG_71 = 2'h2,
        SPDP_MAG_100 = 2'h3
    } spdp_mag_t;
    // chopping threshold as percent of full scale
    localparam logic [6:0] SPDP_PCT_0 = 7'h00;
    localparam logic [6:0] SPDP_PCT_38 = 7'h26;
    localparam logic [6:0] SPDP_PCT_71 = 7'h47;
    localparam logic [6:0] SPDP_PCT_100 = 7'h64;
    localparam int SPDP_NUM_CHAN = 2;
    // controller toggle-rate limits and edge time
    localparam int SPDP_PHASE_MIN_HZ = 1000;
    localparam int SPDP_PHASE_MAX_HZ = 400000;
    localparam int SPDP_RISE_MAX_NS = 500;
    localparam int SPDP_CLK_HZ = 25000000;
    // shortest legal half period of a direction toggle, rounded up
    localparam int SPDP_HALF_MIN_CYC = (SPDP_CLK_HZ + 2 * SPDP_PHASE_MAX_HZ - 1)
        / (2 * SPDP_PHASE_MAX_HZ);
    // longest legal half period, rounded down (above 4096: host parameter default)
    localparam int SPDP_HALF_MAX_CYC = SPDP_CLK_HZ / (2 * SPDP_PHASE_MIN_HZ);
    // standby clear-sequence states, gray along high -> low -> high
    typedef enum logic [1:0] {
        SPDP_SB_IDLE = 2'h0,
        SPDP_SB_SAW_HI = 2'h1,
        SPDP_SB_SAW_LO = 2'h3
    } spdp_sb_t;
    // host stepping states
    typedef enum logic [1:0] {
        SPDP_H_OFF = 2'h0,
        SPDP_H_RUN = 2'h1
    } spdp_host_t;
endpackage : spdp_pkg

// ### rtl/spdp_if.sv
`timescale 1ns/1ps
interface spdp_if;
    logic [1:0] dir;       // direction per channel, high = plus to minus
    logic [1:0] sel_hi;    // first level select per channel
    logic [1:0] sel_lo;    // second level select per channel
    logic standby_n;       // low = standby
    modport dev (input dir, input sel_hi, input sel_lo, input standby_n);
    modport host (output dir, output sel_hi, output sel_lo, output standby_n);
endinterface : spdp_if

// ### rtl/spdp_host.sv
`timescale 1ns/1ps
module spdp_host #(
    parameter int HALF_CYC = spdp_pkg::SPDP_HALF_MAX_CYC // cycles per direction half period
) (
    input wire logic clk,            // 25 mhz clock
    input wire logic rst_n,          // async reset, active low
    spdp_if.host link,               // driver pins
    input wire logic run,            // 1 = step, 0 = hold selects low
    input wire logic wake,           // 1 = standby high
    input wire logic [1:0] mag_a,    // magnitude code chan a
    input wire logic [1:0] mag_b,    // magnitude code chan b
    output logic busy                // stepping active
);
    import spdp_pkg::*;
    logic [31:0] cnt_d, cnt_q;
    logic [1:0] dir_d, dir_q, hi_d, hi_q, lo_d, lo_q;
    logic sb_d, sb_q;
    spdp_host_t st_d, st_q;
    // toggle rate clamp
    // half period raised to at least the legal minimum; no upper clamp
    localparam int HC = (HALF_CYC < SPDP_HALF_MIN_CYC) ? SPDP_HALF_MIN_CYC : HALF_CYC;
    ////////////////////////////////////////////////////////////////////////
    // full-step quadrature on the direction pins
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        dir_d = dir_q;
        hi_d = hi_q;
        lo_d = lo_q;
        sb_d = wake;
        unique case (st_q)
            SPDP_H_OFF: begin
                // selects low idle
                // selects stay low while idle so the bridges float
                hi_d = 2'h0;
                lo_d = 2'h0;
                if (run) st_d = SPDP_H_RUN;
            end
            SPDP_H_RUN: begin
                hi_d = {mag_b[1], mag_a[1]};
                lo_d = {mag_b[0], mag_a[0]};
                if (cnt_q >= 32'(HC - 1)) begin
                    cnt_d = 32'h0;
                    dir_d = {dir_q[0], ~dir_q[1]};
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
                if (!run) st_d = SPDP_H_OFF;
            end
            default: st_d = SPDP_H_OFF;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= SPDP_H_OFF;
            cnt_q <= 32'h0;
            dir_q <= 2'h0;
            hi_q <= 2'h0;
            lo_q <= 2'h0;
            sb_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            dir_q <= dir_d;
            hi_q <= hi_d;
            lo_q <= lo_d;
            sb_q <= sb_d;
        end
    end
    // pins from flops
    // every pin comes straight from a flop, so edges are clean and glitch free
    assign link.dir = dir_q;
    assign link.sel_hi = hi_q;
    assign link.sel_lo = lo_q;
    assign link.standby_n = sb_q;
    assign busy = (st_q == SPDP_H_RUN);
endmodule : spdp_host

// ### tb/spdp_monitor.sv
`timescale 1ns/1ps
module spdp_monitor (
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic [1:0] dir, // direction
    input wire logic [1:0] sel_hi, // select hi
    input wire logic [1:0] sel_lo, // select lo
    input wire logic standby_n, // standby
    input wire logic motor_supply_ok, // supply
    input wire logic logic_supply_ok, // supply
    input wire logic thermal_shutdown, // fault pin
    input wire logic [1:0] overcurrent_shutdown, // fault pins
    input wire logic [1:0] drive_pos, // plus leg
    input wire logic [1:0] drive_neg, // minus leg
    input wire logic [1:0] out_oe_n, // bridge off
    input wire logic [27:0] chop_level, // levels
    input wire logic osc_en, // oscillator
    input wire logic therm_latched, // latch
    input wire logic [1:0] ocp_latched // latches
);
import spdp_pkg::*;
logic [1:0] age_q;
logic [1:0] age_d;
logic up;
// $past reaches back 3 edges, so hold off until that history is post-reset
always_comb age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) age_q <= 2'h0;
    else age_q <= age_d;
end
assign up = (age_q == 2'h3);
function automatic logic [6:0] pct(logic [1:0] m);
    return m[1] ? (m[0] ? SPDP_PCT_100 : SPDP_PCT_71) : (m[0] ? SPDP_PCT_38 : SPDP_PCT_0);
endfunction : pct
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
///////////////////////////////////////////////////////////////////////////////
chk_lane_a_level: assert property (up && !out_oe_n[0] |->
    chop_level[6:0] == pct({$past(sel_hi[0], 3), $past(sel_lo[0], 3)})) else $error("lane a");
chk_lane_b_level: assert property (up && !out_oe_n[1] |->
    chop_level[13:7] == pct({$past(sel_hi[1], 3), $past(sel_lo[1], 3)})) else $error("lane b");
chk_dir_legs: assert property (up && !out_oe_n[0] |->
    drive_pos[0] == $past(dir[0], 3) && drive_neg[0] != $past(dir[0], 3)) else $error("legs");
chk_zero_hiz: assert property (up |->
    ((~$past(sel_hi | sel_lo, 3)) & ~out_oe_n) == 2'h0) else $error("zero not off");
chk_standby_off: assert property (up && !$past(standby_n, 3) |->
    out_oe_n == 2'h3 && !osc_en) else $error("standby drive");
// latch state shows one edge later than the select-to-output path, on the same edge as the drive shutoff, hence the extra cycle
chk_therm_set: assert property (up && $past(thermal_shutdown, 3) |=> therm_latched)
    else $error("thermal not latched");
chk_therm_off: assert property (therm_latched && $past(therm_latched) |-> out_oe_n == 2'h3)
    else $error("thermal drive");
chk_ocp_set: assert property (up |=> ($past(overcurrent_shutdown, 4) & ~ocp_latched) == 2'h0)
    else $error("ocp not latched");
chk_ocp_off: assert property ((ocp_latched & $past(ocp_latched) & ~out_oe_n) == 2'h0)
    else $error("ocp drive");
chk_supply_off: assert property (up && !$past(motor_supply_ok & logic_supply_ok, 3) |->
    out_oe_n == 2'h3) else $error("supply drive");
endmodule : spdp_monitor

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
import spdp_pkg::*;
logic clk = 1'b0;
logic rst_n = 1'b0;
logic run = 1'b0, wake = 1'b0, m_ok = 1'b0, l_ok = 1'b0, hot = 1'b0;
logic [1:0] mag_a = 2'h0, mag_b = 2'h0, ocp = 2'h0, pos, neg, oe_n, ocl, en;
logic [27:0] lvl;
logic osc, thl, busy;
logic [5:0] q1, q2, q3;
int n_fail = 0, compares = 0;
always #20 clk = ~clk;
spdp_if bus();
// 32 cycles per half period is the fastest legal toggle
spdp_host #(.HALF_CYC(32)) u_spdp_host (.clk(clk), .rst_n(rst_n), .link(bus), .run(run),
    .wake(wake), .mag_a(mag_a), .mag_b(mag_b), .busy(busy));
spdp_driver u_spdp_driver (.clk(clk), .rst_n(rst_n), .link(bus), .motor_supply_ok(m_ok),
    .logic_supply_ok(l_ok), .thermal_shutdown(hot), .overcurrent_shutdown(ocp),
    .drive_pos(pos), .drive_neg(neg), .out_oe_n(oe_n), .chop_level(lvl), .osc_en(osc),
    .therm_latched(thl), .ocp_latched(ocl));
spdp_monitor u_spdp_monitor (.clk(clk), .rst_n(rst_n), .dir(bus.dir), .sel_hi(bus.sel_hi),
    .sel_lo(bus.sel_lo), .standby_n(bus.standby_n), .motor_supply_ok(m_ok),
    .logic_supply_ok(l_ok), .thermal_shutdown(hot), .overcurrent_shutdown(ocp),
    .drive_pos(pos), .drive_neg(neg), .out_oe_n(oe_n), .chop_level(lvl), .osc_en(osc),
    .therm_latched(thl), .ocp_latched(ocl));
// pins delayed as through the driver's synchronisers and output flops: {dir, hi1, lo1, hi0, lo0}
always @(posedge clk) begin
    q1 <= {bus.dir, bus.sel_hi[1], bus.sel_lo[1], bus.sel_hi[0], bus.sel_lo[0]};
    q2 <= q1;
    q3 <= q2;
end
assign en = {q3[3] | q3[2], q3[1] | q3[0]};
function automatic logic [6:0] pct(logic [1:0] m);
    return m[1] ? (m[0] ? SPDP_PCT_100 : SPDP_PCT_71) : (m[0] ? SPDP_PCT_38 : SPDP_PCT_0);
endfunction : pct
task chk(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (e !== g) begin
        n_fail++;
        $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
endtask : chk
// settle one ns past the edge so registered outputs have landed
task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
endtask : cyc
task complete_run;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
endtask : complete_run
///////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    chk(4'h0, {bus.sel_hi, bus.sel_lo});
    @(posedge clk);
    {m_ok, l_ok, wake, run} <= 4'hf;
    // every magnitude code on both lanes, lanes crossed so each sees all four
    for (int m = 0; m < 4; m++) begin
        @(posedge clk);
        mag_a <= 2'(m);
        mag_b <= ~2'(m);
        cyc(40);
        chk({mag_b, mag_a}, q1[3:0]);
        chk({14'h0, pct(q3[3:2]), pct(q3[1:0])}, lvl);
        chk({q3[5:4] & en, ~q3[5:4] & en, ~en}, {pos & en, neg & en, oe_n});
    end
    @(posedge clk);
    // channel b must be live so the trip is seen to stop only channel a
    mag_b <= 2'h3;
    ocp <= 2'h1;
    cyc(1);
    ocp <= 2'h0;
    cyc(40);
    chk(4'h5, {ocl, oe_n});
    @(posedge clk);
    wake <= 1'b0;
    cyc(5);
    chk(5'h18, {oe_n, osc, ocl});
    @(posedge clk);
    wake <= 1'b1;
    cyc(40);
    chk(2'h0, oe_n);
    @(posedge clk);
    hot <= 1'b1;
    cyc(2);
    hot <= 1'b0;
    cyc(5);
    chk(3'h7, {thl, oe_n});
    wake <= 1'b0;
    cyc(5);
    chk(1'b1, thl);
    wake <= 1'b1;
    cyc(40);
    chk(3'h0, {thl, oe_n});
    hot <= 1'b1;
    cyc(2);
    hot <= 1'b0;
    m_ok <= 1'b0;
    cyc(5);
    chk(3'h3, {thl, oe_n});
    m_ok <= 1'b1;
    l_ok <= 1'b0;
    cyc(5);
    chk(2'h3, oe_n);
    l_ok <= 1'b1;
    cyc(40);
    chk(3'h0, {thl, oe_n});
    complete_run();
end
endmodule : tb
